// [design/mms_defs.svh]
// Address map, bit positions and timing counts of the memory block
`ifndef MMS_DEFS_SVH
`define MMS_DEFS_SVH
`define MMS_IO_BASE 16'h0020
`define MMS_EXT_BASE 16'h0060
`define MMS_SRAM_BASE 16'h0100
`define MMS_SRAM_TOP 16'h08ff
`define MMS_EE_CTL 16'h003f
`define MMS_EE_ADH 16'h0042
`define MMS_BIT_RD 0
`define MMS_BIT_WR 1
`define MMS_BIT_ARM 2
`define MMS_ARM_CYC 3'h4
`define MMS_RD_STALL 3'h4
`define MMS_WR_STALL 3'h2
`define MMS_EE_WR_NS 3400000
`define MMS_CLK_NS 8
`define MMS_BOOT_START 14'h3800
`define MMS_A_CTRL 8'h00
`define MMS_A_STAT 8'h04
`define MMS_A_PMADR 8'h08
`define MMS_A_PMDAT 8'h0c
`define MMS_RESP_OK 2'h0
`define MMS_RESP_ERR 2'h2
`endif

// [design/mms_pkg.sv]
// Types shared by the memory block modules
package mms_pkg;
    typedef enum logic [2:0] {MMS_AM_DIRECT = 3'b000, MMS_AM_DISP = 3'b001,
        MMS_AM_IND = 3'b010, MMS_AM_PREDEC = 3'b011, MMS_AM_POSTINC = 3'b100,
        MMS_AM_IOSHORT = 3'b101} mms_mode_t;
    typedef enum logic [1:0] {MMS_PTR_X = 2'b00, MMS_PTR_Y = 2'b01,
        MMS_PTR_Z = 2'b10} mms_ptr_t;
    typedef enum logic [2:0] {MMS_RG_REGF = 3'b000, MMS_RG_IO = 3'b001,
        MMS_RG_EXT = 3'b010, MMS_RG_SRAM = 3'b011, MMS_RG_NONE = 3'b100} mms_region_t;
    typedef enum logic [0:0] {MMS_CPU_IDLE = 1'b0, MMS_CPU_SRAM = 1'b1} mms_cpu_state_t;
    typedef enum logic [0:0] {MMS_EE_IDLE = 1'b0, MMS_EE_WRITE = 1'b1} mms_ee_state_t;
endpackage

// [design/mms_sram.sv]
// Internal data SRAM, two-cycle access
`timescale 1ns/1ps
`default_nettype none
module mms_sram (
    input wire logic clk, // Core clock
    input wire logic rst, // Sync reset
    input wire logic req, // Access taken
    input wire logic we, // Store when high
    input wire logic [10:0] addr, // Byte offset
    input wire logic [7:0] wdata, // Store data
    output logic [7:0] rdata, // Load data
    output logic ack // Access done
);
    import mms_pkg::*;
    logic [7:0] mem [0:2047];
    logic pend_ff;
    logic we_ff;
    logic [10:0] addr_ff;
    logic [7:0] wd_ff;
    always_ff @(posedge clk)
    begin
        pend_ff <= rst ? 1'b0 : req;
        ack <= rst ? 1'b0 : pend_ff;
        if (req)
        begin
            we_ff <= we;
            addr_ff <= addr;
            wd_ff <= wdata;
        end
    end
    always_ff @(posedge clk)
    begin
        if (pend_ff && we_ff)
            mem[addr_ff] <= wd_ff;
        if (pend_ff)
            rdata <= mem[addr_ff];
    end
endmodule
`default_nettype wire

// [design/mms_eeprom.sv]
// Data EEPROM control: arming, self-timed write, read, power-down hold
`timescale 1ns/1ps
`default_nettype none
`include "mms_defs.svh"
module mms_eeprom #(
    parameter logic [19:0] WR_CYCLES = 20'h1
) (
    input wire logic clk, // Core clock
    input wire logic rst, // Sync reset
    input wire logic por, // Power-on reset
    input wire logic supply_ok, // Supply good, synchronised
    input wire logic pd_req, // Power-down sleep requested
    input wire logic wr, // Register write
    input wire logic [1:0] sel, // 0 ctl, 1 data, 2 addr lo, 3 addr hi
    input wire logic [7:0] wbyte, // Written value
    output logic [7:0] rbyte, // Selected register value
    output logic rd_go, // Read accepted
    output logic wr_go, // Write accepted
    output logic busy, // Write in progress
    output logic osc_run // Timing clock kept running
);
    import mms_pkg::*;
    logic [7:0] mem [0:1023];
    logic [2:0] arm_cnt_ff;
    logic [9:0] addr_ff;
    logic [7:0] data_ff;
    logic [9:0] wa_ff;
    logic [7:0] wd_ff;
    logic [19:0] tmr_ff;
    mms_ee_state_t state_ff;
    logic keep_ff;
    logic arm;
    logic ctl_wr;
    logic arm_load;
    assign arm = arm_cnt_ff != 3'h0;
    assign busy = state_ff == MMS_EE_WRITE;
    assign ctl_wr = wr && sel == 2'h0;
    assign arm_load = ctl_wr && wbyte[`MMS_BIT_ARM];
    // Strobe without a live arm window does nothing
    assign wr_go = ctl_wr && wbyte[`MMS_BIT_WR] && arm && !busy;
    assign rd_go = ctl_wr && wbyte[`MMS_BIT_RD] && !busy && !wr_go;
    assign osc_run = busy || keep_ff;
    always_ff @(posedge clk)
    begin
        if (rst)
            arm_cnt_ff <= 3'h0;
        else if (arm_load)
            arm_cnt_ff <= `MMS_ARM_CYC;
        else if (arm)
            arm_cnt_ff <= arm_cnt_ff - 3'h1;
    end
    // Only power-on clears the engine, so a plain reset never aborts a write
    always_ff @(posedge clk)
    begin
        if (por)
        begin
            state_ff <= MMS_EE_IDLE;
            tmr_ff <= 20'h0;
        end
        else
            case (state_ff)
                MMS_EE_IDLE:
                    if (wr_go)
                    begin
                        state_ff <= MMS_EE_WRITE;
                        tmr_ff <= WR_CYCLES;
                        wa_ff <= addr_ff;
                        wd_ff <= data_ff;
                    end
                MMS_EE_WRITE:
                    if (supply_ok)
                    begin
                        if (tmr_ff == 20'h1)
                            state_ff <= MMS_EE_IDLE;
                        tmr_ff <= tmr_ff - 20'h1;
                    end
                default: state_ff <= MMS_EE_IDLE;
            endcase
    end
    always_ff @(posedge clk)
    begin
        if (busy && supply_ok && tmr_ff == 20'h1)
            mem[wa_ff] <= wd_ff;
    end
    always_ff @(posedge clk)
    begin
        if (rst && !busy)
            addr_ff <= 10'h0;
        else if (wr && !busy && sel == 2'h2)
            addr_ff[7:0] <= wbyte;
        else if (wr && !busy && sel == 2'h3)
            addr_ff[9:8] <= wbyte[1:0];
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            data_ff <= 8'h0;
        else if (rd_go)
            data_ff <= mem[addr_ff];
        else if (wr && sel == 2'h1)
            data_ff <= wbyte;
    end
    always_ff @(posedge clk)
    begin
        if (por || !pd_req)
            keep_ff <= 1'b0;
        else if (busy)
            keep_ff <= 1'b1;
    end
    always_comb
    begin
        case (sel)
            2'h0: rbyte = {5'h0, arm, busy, 1'b0};
            2'h1: rbyte = data_ff;
            2'h2: rbyte = addr_ff[7:0];
            default: rbyte = {6'h0, addr_ff[9:8]};
        endcase
    end
    sequence s_arm_quiet;
        arm_load ##1 !arm_load [*4];
    endsequence
    property p_arm_window;
        @(posedge clk) disable iff (rst) s_arm_quiet |-> arm ##1 !arm;
    endproperty
    a_arm_window: assert property (p_arm_window) else $error("arm window not four cycles");
    property p_addr_hold;
        @(posedge clk) disable iff (por) busy |=> $stable(addr_ff);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved during write");
    property p_no_abort;
        @(posedge clk) disable iff (por) (rst && busy && tmr_ff > 20'h1) |=> busy;
    endproperty
    a_no_abort: assert property (p_no_abort) else $error("reset aborted a write");
    property p_pd_keep;
        @(posedge clk) disable iff (por) (pd_req && busy) ##1 pd_req |-> osc_run;
    endproperty
    a_pd_keep: assert property (p_pd_keep) else $error("timing clock stopped");
    property p_no_arm;
        @(posedge clk) disable iff (por || rst)
            (ctl_wr && wbyte[`MMS_BIT_WR] && !arm && !busy) |=> !busy;
    endproperty
    a_no_arm: assert property (p_no_arm) else $error("unarmed strobe started write");
endmodule
`default_nettype wire

// [design/mms_top.sv]
// Memory space decoder, program store, data EEPROM access and AXI4-Lite slave
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mms_defs.svh"
module mms_top #(
    parameter logic [19:0] EE_WR_CYCLES = 20'(`MMS_EE_WR_NS / `MMS_CLK_NS)
) (
    input wire logic clk, // Core clock, 125 MHz
    input wire logic rst, // Sync reset, active high
    input wire logic por, // Power-on reset, clears write engine
    input wire logic supply_ok, // Supply good pin
    input wire logic [13:0] program_counter, // Fetch word address
    output logic [15:0] fetch_word, // Fetched word
    input wire logic [14:0] lpm_addr, // Program-memory load byte address
    output logic [7:0] lpm_byte, // Loaded program byte
    input wire logic cpu_req, // Data access request
    input wire logic cpu_we, // Store when high
    input wire mms_pkg::mms_mode_t cpu_mode, // Addressing mode
    input wire mms_pkg::mms_ptr_t cpu_ptr, // Pointer pair
    input wire logic [15:0] cpu_addr, // Direct or short I/O address
    input wire logic [5:0] cpu_disp, // Displacement
    input wire logic [7:0] cpu_wdata, // Store data
    output logic cpu_ready, // Request can be taken
    output logic cpu_ack, // Access done pulse
    output logic [7:0] cpu_rdata, // Load data
    output logic cpu_stall, // CPU halted
    output logic pd_full, // Full power-down reached
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read valid
    input wire logic s_axi_rready // Read ready
);
    import mms_pkg::*;

    function automatic mms_region_t region_of(input logic [15:0] a);
        if (a < `MMS_IO_BASE)
            return MMS_RG_REGF;
        else if (a < `MMS_EXT_BASE)
            return MMS_RG_IO;
        else if (a < `MMS_SRAM_BASE)
            return MMS_RG_EXT;
        else if (a <= `MMS_SRAM_TOP)
            return MMS_RG_SRAM;
        else
            return MMS_RG_NONE;
    endfunction

    logic [15:0] pm [0:16383];
    logic [7:0] regs [0:31];
    logic [7:0] io_mem [0:63];
    logic [7:0] ext_mem [0:159];
    logic sup_s1_ff;
    logic sup_s2_ff;
    mms_cpu_state_t state_ff;
    logic [2:0] stall_ff;
    logic ack_ff;
    logic [7:0] rdata_ff;
    logic [2:0] ctrl_ff;
    logic [13:0] pmadr_ff;
    logic aw_ff;
    logic w_ff;
    logic [7:0] awa_ff;
    logic [31:0] wd_ff;
    logic [3:0] ws_ff;
    logic wr_fire;
    logic take;
    logic [4:0] pidx;
    logic [15:0] ptr;
    logic [15:0] ea;
    mms_region_t region;
    logic ee_hit;
    logic [1:0] ee_sel;
    logic [7:0] ee_rbyte;
    logic ee_rd_go;
    logic ee_wr_go;
    logic ee_busy;
    logic osc_run;
    logic sram_req;
    logic sram_ack;
    logic [7:0] sram_rdata;
    logic pm_lock;

    // Pin crossing
    always_ff @(posedge clk)
    begin
        sup_s1_ff <= supply_ok;
        sup_s2_ff <= sup_s1_ff;
    end

    // Program store: fetch and byte load
    always_ff @(posedge clk)
    begin
        fetch_word <= pm[program_counter];
        lpm_byte <= lpm_addr[0] ? pm[lpm_addr[14:1]][15:8] : pm[lpm_addr[14:1]][7:0];
    end

    assign pm_lock = (pmadr_ff >= `MMS_BOOT_START) ? ctrl_ff[1] : ctrl_ff[0];

    always_ff @(posedge clk)
    begin
        if (wr_fire && awa_ff == `MMS_A_PMDAT && ws_ff[1:0] == 2'h3 && !pm_lock)
            pm[pmadr_ff] <= wd_ff[15:0];
    end

    // Effective address
    assign pidx = 5'h1a + {2'h0, cpu_ptr, 1'b0};
    assign ptr = {regs[pidx + 5'h1], regs[pidx]};

    always_comb
    begin
        case (cpu_mode)
            MMS_AM_DIRECT: ea = cpu_addr;
            MMS_AM_IOSHORT: ea = `MMS_IO_BASE + {10'h0, cpu_addr[5:0]};
            MMS_AM_DISP: ea = ptr + {10'h0, cpu_disp};
            MMS_AM_PREDEC: ea = ptr - 16'h1;
            default: ea = ptr;
        endcase
    end

    assign region = region_of(ea);
    assign ee_hit = ea >= `MMS_EE_CTL && ea <= `MMS_EE_ADH;
    assign ee_sel = ea[1:0] + 2'h1;
    assign cpu_ready = (state_ff == MMS_CPU_IDLE || sram_ack) && stall_ff == 3'h0;
    assign take = cpu_req && cpu_ready;
    assign sram_req = take && region == MMS_RG_SRAM;

    // Register file with pointer write-back
    always_ff @(posedge clk)
    begin
        if (take && cpu_we && region == MMS_RG_REGF)
            regs[ea[4:0]] <= cpu_wdata;
        if (take && cpu_mode == MMS_AM_PREDEC)
        begin
            regs[pidx] <= ea[7:0];
            regs[pidx + 5'h1] <= ea[15:8];
        end
        else if (take && cpu_mode == MMS_AM_POSTINC)
        begin
            regs[pidx] <= 8'(ptr + 16'h1);
            regs[pidx + 5'h1] <= 8'((ptr + 16'h1) >> 8);
        end
    end

    // I/O and extended I/O; nothing above SRAM is stored
    always_ff @(posedge clk)
    begin
        if (take && cpu_we && region == MMS_RG_IO && !ee_hit)
            io_mem[ea[5:0] - 6'h20] <= cpu_wdata;
        if (take && cpu_we && region == MMS_RG_EXT)
            ext_mem[ea[7:0] - 8'h60] <= cpu_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_ff <= 1'b0;
            rdata_ff <= 8'h0;
        end
        else
        begin
            ack_ff <= take && region != MMS_RG_SRAM;
            if (take && !cpu_we)
                case (region)
                    MMS_RG_REGF: rdata_ff <= regs[ea[4:0]];
                    MMS_RG_IO: rdata_ff <= ee_hit ? ee_rbyte : io_mem[ea[5:0] - 6'h20];
                    MMS_RG_EXT: rdata_ff <= ext_mem[ea[7:0] - 8'h60];
                    default: rdata_ff <= 8'h0;
                endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            state_ff <= MMS_CPU_IDLE;
        else
            case (state_ff)
                MMS_CPU_IDLE:
                    if (sram_req)
                        state_ff <= MMS_CPU_SRAM;
                MMS_CPU_SRAM:
                    if (sram_ack && !sram_req)
                        state_ff <= MMS_CPU_IDLE;
                default: state_ff <= MMS_CPU_IDLE;
            endcase
    end

    // Halt after an accepted EEPROM strobe
    always_ff @(posedge clk)
    begin
        if (rst)
            stall_ff <= 3'h0;
        else if (ee_wr_go)
            stall_ff <= `MMS_WR_STALL;
        else if (ee_rd_go)
            stall_ff <= `MMS_RD_STALL;
        else if (stall_ff != 3'h0)
            stall_ff <= stall_ff - 3'h1;
    end

    assign cpu_stall = stall_ff != 3'h0;
    assign cpu_ack = ack_ff || sram_ack;
    assign cpu_rdata = sram_ack ? sram_rdata : rdata_ff;
    // Software should wait for idle before sleeping, else power stays up
    assign pd_full = ctrl_ff[2] && !osc_run;

    mms_sram u_sram (
        .clk(clk),
        .rst(rst),
        .req(sram_req),
        .we(cpu_we),
        .addr(ea[10:0] - 11'h100),
        .wdata(cpu_wdata),
        .rdata(sram_rdata),
        .ack(sram_ack)
    );

    mms_eeprom #(
        .WR_CYCLES(EE_WR_CYCLES)
    ) u_ee (
        .clk(clk),
        .rst(rst),
        .por(por),
        .supply_ok(sup_s2_ff),
        .pd_req(ctrl_ff[2]),
        .wr(take && cpu_we && ee_hit),
        .sel(ee_sel),
        .wbyte(cpu_wdata),
        .rbyte(ee_rbyte),
        .rd_go(ee_rd_go),
        .wr_go(ee_wr_go),
        .busy(ee_busy),
        .osc_run(osc_run)
    );

    // AXI4-Lite write channel
    assign s_axi_awready = !aw_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_ff && !s_axi_bvalid;
    assign wr_fire = aw_ff && w_ff && !s_axi_bvalid;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MMS_RESP_OK;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ff <= 1'b1;
                awa_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ff <= 1'b1;
                wd_ff <= s_axi_wdata;
                ws_ff <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awa_ff == `MMS_A_CTRL || awa_ff == `MMS_A_STAT ||
                    awa_ff == `MMS_A_PMADR || awa_ff == `MMS_A_PMDAT) ?
                    `MMS_RESP_OK : `MMS_RESP_ERR;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_ff <= 3'h0;
            pmadr_ff <= 14'h0;
        end
        else if (wr_fire && awa_ff == `MMS_A_CTRL && ws_ff[0])
            ctrl_ff <= wd_ff[2:0];
        else if (wr_fire && awa_ff == `MMS_A_PMADR && ws_ff[1:0] == 2'h3)
            pmadr_ff <= wd_ff[13:0];
    end

    // AXI4-Lite read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `MMS_RESP_OK;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `MMS_RESP_OK;
            case (s_axi_araddr)
                `MMS_A_CTRL: s_axi_rdata <= {29'h0, ctrl_ff};
                `MMS_A_STAT: s_axi_rdata <= {28'h0, cpu_stall, pd_full, osc_run, ee_busy};
                `MMS_A_PMADR: s_axi_rdata <= {18'h0, pmadr_ff};
                `MMS_A_PMDAT: s_axi_rdata <= {16'h0, pm[pmadr_ff]};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `MMS_RESP_ERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    sequence s_rd_halt;
        cpu_stall [*4] ##1 !cpu_stall;
    endsequence
    property p_rd_stall;
        @(posedge clk) disable iff (rst) ee_rd_go |=> s_rd_halt;
    endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("read stall not four cycles");
    property p_wr_stall;
        @(posedge clk) disable iff (rst) ee_wr_go |=> cpu_stall [*2] ##1 !cpu_stall;
    endproperty
    a_wr_stall: assert property (p_wr_stall) else $error("write stall not two cycles");
    property p_sram_time;
        @(posedge clk) disable iff (rst) sram_req |=> !cpu_ack ##1 (cpu_ack && cpu_ready);
    endproperty
    a_sram_time: assert property (p_sram_time) else $error("SRAM access not two cycles");
    property p_fast_ack;
        @(posedge clk) disable iff (rst) (take && region != MMS_RG_SRAM) |=> cpu_ack;
    endproperty
    a_fast_ack: assert property (p_fast_ack) else $error("register access not acked");
    property p_postinc;
        @(posedge clk) disable iff (rst) (take && cpu_mode == MMS_AM_POSTINC) |=>
            {regs[$past(pidx) + 5'h1], regs[$past(pidx)]} == $past(ptr) + 16'h1;
    endproperty
    a_postinc: assert property (p_postinc) else $error("pointer not incremented");
    property p_above_top;
        @(posedge clk) disable iff (rst) (take && !cpu_we && region == MMS_RG_NONE) |=>
            cpu_ack && cpu_rdata == 8'h0;
    endproperty
    a_above_top: assert property (p_above_top) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// [tb/mms_cpu_model.sv]
// CPU core model issuing loads and stores on the data port, in the addressing mode the bench selects
`timescale 1ns/1ps
`default_nettype none
module mms_cpu_model (
    input wire logic clk, // Core clock
    output logic cpu_req, // Request
    output logic cpu_we, // Store
    output logic [15:0] cpu_addr, // Address
    output logic [7:0] cpu_wdata, // Store data
    input wire logic cpu_ready, // Take allowed
    input wire logic cpu_ack, // Done
    input wire logic [7:0] cpu_rdata, // Load data
    input wire logic cpu_stall // Halted
);
    initial {cpu_req, cpu_we, cpu_addr, cpu_wdata} = '0;
    // Returns cycles to ack and stall cycles seen after the take
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] q, output int n, output int s);
        {n, s, q} = '0;
        @(posedge clk);
        {cpu_req, cpu_we, cpu_addr, cpu_wdata} <= {1'b1, w, a, d};
        for (int i = 0; i < 30; i++)
        begin
            @(negedge clk);
            if (cpu_ready === 1'b1)
                break;
        end
        if (cpu_ready !== 1'b1)
            tb_top.to();
        @(posedge clk);
        // Released data bus shows no stale byte
        {cpu_req, cpu_wdata} <= {1'b0, ~d};
        for (int i = 1; i < 30 && (n == 0 || cpu_stall === 1'b1); i++)
        begin
            @(negedge clk);
            s += int'(cpu_stall === 1'b1);
            if (cpu_ack === 1'b1)
                {n, q} = {i, cpu_rdata};
        end
        if (n == 0)
            tb_top.to();
    endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Bench for data map, EEPROM control and program store of the memory block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mms_pkg::*;
    logic clk, rst, por, cpu_req, cpu_we, cpu_ready, cpu_ack, cpu_stall, pd_full;
    mms_mode_t cpu_mode = MMS_AM_DIRECT;
    mms_ptr_t cpu_ptr = MMS_PTR_X;
    logic [5:0] cpu_disp = 6'h00;
    logic [13:0] program_counter;
    logic [15:0] fetch_word, cpu_addr;
    logic [7:0] cpu_wdata, cpu_rdata, lpm_byte, q, s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, r;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] ad [5] = '{16'h001f, 16'h0000, 16'h0100, 16'h08ff, 16'h0500};
    int fails = 0, checks_done = 0, n, s, i, k;
    mms_top #(.EE_WR_CYCLES(20'h14)) dut (.clk, .rst, .por, .supply_ok(1'b1),
        .program_counter, .fetch_word, .lpm_addr({program_counter, 1'b1}), .lpm_byte,
        .cpu_req, .cpu_we, .cpu_mode, .cpu_ptr, .cpu_addr,
        .cpu_disp, .cpu_wdata, .cpu_ready, .cpu_ack, .cpu_rdata, .cpu_stall,
        .pd_full, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    mms_cpu_model u_cpu (.clk, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_ready,
        .cpu_ack, .cpu_rdata, .cpu_stall);
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string t);
        checks_done++;
        if (g !== e)
        begin
            $display("[FAIL] %0t %s", $time, t);
            fails++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic to();
        fails++;
        tally_and_finish();
    endtask
    task automatic st(input logic [15:0] a, input logic [7:0] d);
        u_cpu.acc(1'b1, a, d, q, n, s);
    endtask
    task automatic ld(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e,
        input string t);
        u_cpu.acc(1'b0, a, 8'h00, q, n, s);
        chk(32'(q & m), 32'(e), t);
    endtask
    // Addressing mode for the following accesses, changed between requests only
    task automatic md(input mms_mode_t m, input mms_ptr_t p, input logic [5:0] d);
        @(posedge clk);
        cpu_mode <= m;
        cpu_ptr <= p;
        cpu_disp <= d;
    endtask
    // One AXI4-Lite write or read, channels released as each is taken
    task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] e);
        @(posedge clk);
        if (w)
            {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} <= {a, 1'b1, d, 2'b11};
        else
            {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        for (i = 0; i == 0 || s_axi_bready || s_axi_rready; i++)
        begin
            @(posedge clk);
            if (i > 30)
                to();
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
            s_axi_bready <= s_axi_bready && !s_axi_bvalid;
            s_axi_rready <= s_axi_rready && !s_axi_rvalid;
            if (s_axi_bvalid && s_axi_bready)
                chk(32'(s_axi_bresp), 32'(e), "bresp");
            if (s_axi_rvalid && s_axi_rready)
                {r, k} = {s_axi_rdata, int'(s_axi_rresp)};
        end
        if (!w)
            chk(32'(k), 32'(e), "rresp");
    endtask
    initial
    begin
        {rst, por, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'b11000;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {program_counter, s_axi_wstrb} = {14'h0000, 4'hf};
        repeat (6) @(posedge clk);
        {rst, por} <= 2'b00;
        for (k = 0; k < 5; k++)
        begin
            st(ad[k], ad[k][7:0] ^ 8'h3c);
            ld(ad[k], 8'hff, ad[k][7:0] ^ 8'h3c, "map data");
            chk(n, (k > 1) ? 2 : 1, "map latency");
        end
        st(16'h0900, 8'h77);
        ld(16'h0900, 8'hff, 8'h00, "above sram");
        st(16'h001a, 8'h00);
        st(16'h001b, 8'h01);
        st(16'h001c, 8'hf0);
        st(16'h001d, 8'h00);
        md(MMS_AM_POSTINC, MMS_PTR_X, 6'h00);
        ld(16'h0000, 8'hff, 8'h3c, "post-increment load");
        md(MMS_AM_IOSHORT, MMS_PTR_X, 6'h00);
        st(16'h0001, 8'h5a);
        md(MMS_AM_DISP, MMS_PTR_Y, 6'h3f);
        st(16'h0000, 8'h99);
        md(MMS_AM_DIRECT, MMS_PTR_X, 6'h00);
        ld(16'h001a, 8'hff, 8'h01, "pointer written back");
        ld(16'h0021, 8'hff, 8'h5a, "short I/O");
        ld(16'h012f, 8'hff, 8'h99, "displacement");
        $display("test data map done");
        st(16'h0041, 8'hff);
        st(16'h0042, 8'h03);
        st(16'h0040, 8'hc6);
        st(16'h003f, 8'h04);
        ld(16'h003f, 8'h04, 8'h04, "armed");
        repeat (5) @(posedge clk);
        st(16'h003f, 8'h02);
        ld(16'h003f, 8'h06, 8'h00, "late strobe");
        st(16'h003f, 8'h04);
        st(16'h003f, 8'h02);
        chk(s, 2, "write stall");
        st(16'h0041, 8'h00);
        ld(16'h003f, 8'h02, 8'h02, "busy");
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        ax(1'b1, 8'h00, 32'h4, 2'h0);
        for (k = 0; q[1] === 1'b1; k++)
        begin
            if (k > 40)
                to();
            u_cpu.acc(1'b0, 16'h003f, 8'h00, q, n, s);
        end
        ld(16'h0041, 8'hff, 8'hff, "address kept");
        ax(1'b0, 8'h04, 32'h0, 2'h0);
        chk(r, 32'h2, "clock held after write");
        st(16'h0040, 8'h00);
        st(16'h003f, 8'h01);
        chk(s, 4, "read stall");
        ld(16'h0040, 8'hff, 8'hc6, "eeprom byte");
        $display("test eeprom done");
        ax(1'b1, 8'h08, 32'h5, 2'h0);
        ax(1'b1, 8'h0c, 32'h1234, 2'h0);
        program_counter <= 14'h0005;
        repeat (2) @(posedge clk);
        chk(32'(fetch_word), 32'h1234, "fetch");
        chk(32'(lpm_byte), 32'h12, "constant load");
        ax(1'b1, 8'h00, 32'h1, 2'h0);
        ax(1'b1, 8'h0c, 32'h5678, 2'h0);
        ax(1'b0, 8'h0c, 32'h0, 2'h0);
        chk(r, 32'h1234, "section lock");
        ax(1'b0, 8'h10, 32'h0, 2'h2);
        chk(r, 32'h0, "unmapped register");
        $display("test program store done");
        ax(1'b1, 8'h00, 32'h4, 2'h0);
        ax(1'b0, 8'h04, 32'h0, 2'h0);
        chk(r, 32'h4, "full power-down");
        chk(32'(pd_full), 32'h1, "power-down pin");
        $display("test power-down done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
